// ==== rtl/pdr_interlock.sv ====
// pdr_interlock: cutoff/pause latches, request decoding, restart loader
// assumes pins are asynchronous, commands and flash/encoder acks are synchronous
`timescale 1ns/10ps
`default_nettype none
module pdr_interlock
	import pdr_pkg::*;
(
	// clock and reset
	input  wire logic              sys_clk_i,
	input  wire logic              arst_n_i,
	// input ports from the sequencer
	input  wire logic              port14_recover_i,
	input  wire logic              port5_preset_i,
	input  wire logic              port6_pause_i,
	input  wire logic              estop_i,
	input  wire logic              dms_stop_i,
	input  wire logic              cutoff_cause_i,
	// configuration
	input  wire logic              cfg_cutoff_reset_en_i,
	input  wire logic              cfg_pause_reset_en_i,
	input  wire logic              cfg_pause_sig_en_i,
	input  wire logic [1:0]        cfg_estop_rcv_i,
	input  wire logic [1:0]        cfg_dms_rcv_i,
	input  wire logic [1:0]        cfg_battery_i,
	input  wire logic              auto_mode_i,
	// host and pendant commands
	input  wire logic              drive_recovery_cmd_i,
	input  wire logic              pause_reset_cmd_i,
	input  wire logic              soft_reset_i,
	input  wire logic              flash_save_i,
	input  wire logic              param_file_i,
	input  wire logic              host_wr_i,
	input  wire logic [ADDR_W-1:0] host_addr_i,
	input  wire logic [DATA_W-1:0] host_wdata_i,
	output logic      [DATA_W-1:0] host_rdata_o,
	output logic                   busy_o,
	// interlock status
	output logic                   drive_cutoff_o,
	output logic                   op_pause_o,
	output logic                   drive_recovery_req_o,
	output logic                   pause_reset_req_o,
	// flash port
	output logic                   flash_rd_req_o,
	output logic                   flash_wr_req_o,
	output logic      [ADDR_W-1:0] flash_addr_o,
	output logic      [DATA_W-1:0] flash_wdata_o,
	input  wire logic [DATA_W-1:0] flash_rdata_i,
	input  wire logic              flash_ack_i,
	// encoder memory port
	output logic                   enc_rd_req_o,
	output logic                   enc_wr_req_o,
	output logic      [ADDR_W-1:0] enc_addr_o,
	output logic      [DATA_W-1:0] enc_wdata_o,
	input  wire logic [DATA_W-1:0] enc_rdata_i,
	input  wire logic              enc_ack_i
);
	logic [PIN_N-1:0] pin_raw;
	logic [PIN_N-1:0] meta_r, meta_nxt;
	logic [PIN_N-1:0] sync_r, sync_nxt;
	logic [PIN_N-1:0] prev_r, prev_nxt;
	logic [PIN_N-1:0] rise;
	logic             cutoff_r, cutoff_nxt;
	logic             pause_r, pause_nxt;
	logic             rec_req, prs_req;
	logic             estop_pause, dms_pause, sig_pause, pause_cause;
	pdr_state_t       st_r, st_nxt;
	pdr_walk_t        mode_r, mode_nxt;
	logic [ADDR_W-1:0] addr_r, addr_nxt;
	logic             boot_pend_r, boot_pend_nxt;
	logic [1:0]       region;
	logic             at_end;
	pdr_mem_if        m ();

	assign pin_raw = {cutoff_cause_i, dms_stop_i, estop_i,
	                  port6_pause_i, port5_preset_i, port14_recover_i};

	// two-flop synchroniser and edge memory, one process for all pins
	always_comb begin
		meta_nxt = pin_raw;
		sync_nxt = meta_r;
		prev_nxt = sync_r;
	end

	// per-pin edge detect; only the second flop feeds logic
	genvar g;
	generate
		for (g = 0; g < PIN_N; g++) begin : g_pin
			assign rise[g] = sync_r[g] & ~prev_r[g];
		end
	endgenerate

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta_r <= PIN_IDLE; // a low pause flop would fake a pause
			sync_r <= PIN_IDLE;
			prev_r <= PIN_IDLE;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
			prev_r <= prev_nxt;
		end
	end

	// request decode: port edges count only when their function is on, commands always
	assign rec_req = (cfg_cutoff_reset_en_i == FUNC_ON && rise[PIN_RECOVER])
	               | drive_recovery_cmd_i;
	assign prs_req = (cfg_pause_reset_en_i == FUNC_ON && rise[PIN_PRESET])
	               | pause_reset_cmd_i;
	assign drive_recovery_req_o = rec_req;
	assign pause_reset_req_o    = prs_req;

	// pause causes; a stop is only a pause in auto with continued-operation recovery
	assign estop_pause = auto_mode_i && cfg_estop_rcv_i == RCV_CONTINUE
	                   && rise[PIN_ESTOP];
	assign dms_pause   = auto_mode_i && cfg_dms_rcv_i == RCV_CONTINUE && rise[PIN_DMS];
	assign sig_pause   = cfg_pause_sig_en_i == FUNC_ON && !sync_r[PIN_PAUSE];
	// a reset request is ignored while any stop is still held
	assign pause_cause = sig_pause || sync_r[PIN_ESTOP] || sync_r[PIN_DMS];

	// interlock latches; a new cause wins over a same-cycle clear
	always_comb begin
		cutoff_nxt = cutoff_r;
		pause_nxt  = pause_r;
		if (cfg_cutoff_reset_en_i != FUNC_ON) begin
			cutoff_nxt = sync_r[PIN_CAUSE];
		end else if (sync_r[PIN_CAUSE]) begin
			cutoff_nxt = 1'b1;
		end else if (rec_req) begin
			cutoff_nxt = 1'b0;
		end
		if (estop_pause || dms_pause || sig_pause) begin
			pause_nxt = 1'b1;
		end else if (prs_req && !pause_cause) begin
			// order of requests is the requester's job; no check on cutoff here
			pause_nxt = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cutoff_r <= 1'b0;
			pause_r  <= 1'b0;
		end else begin
			cutoff_r <= cutoff_nxt;
			pause_r  <= pause_nxt;
		end
	end
	assign drive_cutoff_o = cutoff_r;
	assign op_pause_o     = pause_r;

	// restart loader, flash save and encoder write-back share one walk
	assign region = addr_r[ADDR_W-1:ADDR_W-2];
	assign at_end = (addr_r == ADDR_LAST);

	always_comb begin
		st_nxt        = st_r;
		mode_nxt      = mode_r;
		addr_nxt      = addr_r;
		boot_pend_nxt = boot_pend_r | soft_reset_i;
		m.we          = 1'b0;
		m.addr        = addr_r;
		m.wdata       = DATA_ZERO;
		case (st_r)
			S_IDLE: begin
				m.addr  = host_addr_i;
				m.we    = host_wr_i;
				m.wdata = host_wdata_i;
				if (boot_pend_r) begin
					boot_pend_nxt = soft_reset_i;
					mode_nxt      = WM_BOOT;
					addr_nxt      = ADDR_FIRST;
					st_nxt        = S_WALK;
				end else if (flash_save_i) begin
					mode_nxt = WM_SAVE;
					addr_nxt = ADDR_FIRST;
					st_nxt   = S_WALK;
				end else if (param_file_i) begin
					mode_nxt = WM_ENC;
					addr_nxt = ENC_USER_BASE;
					st_nxt   = S_WALK;
				end
			end
			S_WALK: begin
				case (mode_r)
					WM_BOOT: begin
						case (region)
							REG_PROG:   st_nxt = S_FLRD;
							REG_POS:    st_nxt = (cfg_battery_i == BATT_NONE) ? S_FLRD : S_WALK;
							REG_GLOBAL: st_nxt = (cfg_battery_i == BATT_SRAM) ? S_WALK : S_CLR;
							default:    st_nxt = S_ENCRD;
						endcase
						if ((region == REG_POS && cfg_battery_i != BATT_NONE)
						    || (region == REG_GLOBAL && cfg_battery_i == BATT_SRAM)) begin
							addr_nxt = addr_r + 8'h01;
						end
					end
					WM_SAVE: st_nxt = (region == REG_ENC) ? S_IDLE : S_MRD;
					default: st_nxt = S_MRD;
				endcase
			end
			S_FLRD: begin
				if (flash_ack_i) begin
					m.we     = 1'b1;
					m.wdata  = flash_rdata_i;
					addr_nxt = addr_r + 8'h01;
					st_nxt   = S_WALK;
				end
			end
			S_CLR: begin
				m.we     = 1'b1;
				addr_nxt = addr_r + 8'h01;
				st_nxt   = S_WALK;
			end
			S_ENCRD: begin
				if (enc_ack_i) begin
					m.we     = 1'b1;
					m.wdata  = enc_rdata_i;
					addr_nxt = addr_r + 8'h01;
					st_nxt   = at_end ? S_IDLE : S_WALK;
				end
			end
			S_MRD: st_nxt = (mode_r == WM_SAVE) ? S_FLWR : S_ENCWR;
			S_FLWR: begin
				if (flash_ack_i) begin
					addr_nxt = addr_r + 8'h01;
					st_nxt   = S_WALK;
				end
			end
			S_ENCWR: begin
				if (enc_ack_i) begin
					addr_nxt = addr_r + 8'h01;
					st_nxt   = at_end ? S_IDLE : S_WALK;
				end
			end
			default: st_nxt = S_IDLE;
		endcase
	end

	// boot pending from reset so power-on runs the full reload
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_r        <= S_IDLE;
			mode_r      <= WM_BOOT;
			addr_r      <= ADDR_FIRST;
			boot_pend_r <= 1'b1;
		end else begin
			st_r        <= st_nxt;
			mode_r      <= mode_nxt;
			addr_r      <= addr_nxt;
			boot_pend_r <= boot_pend_nxt;
		end
	end

	pdr_mem u_mem (
		.sys_clk_i (sys_clk_i),
		.m         (m)
	);

	// outside ports: addresses from the walk counter, data from memory flops
	assign busy_o         = (st_r != S_IDLE);
	assign host_rdata_o   = m.rdata;
	assign flash_rd_req_o = (st_r == S_FLRD);
	assign flash_wr_req_o = (st_r == S_FLWR);
	assign flash_addr_o   = addr_r;
	assign flash_wdata_o  = m.rdata;
	assign enc_rd_req_o   = (st_r == S_ENCRD);
	assign enc_wr_req_o   = (st_r == S_ENCWR);
	assign enc_addr_o     = addr_r;
	assign enc_wdata_o    = m.rdata;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);

	sequence s_estop_in_auto;
		auto_mode_i && cfg_estop_rcv_i == RCV_CONTINUE ##0 rise[PIN_ESTOP];
	endsequence
	sequence s_pause_cleared;
		pause_r && prs_req && !pause_cause && !estop_pause && !dms_pause ##1 !pause_r;
	endsequence

	a_port14_edge_req: assert property (
		cfg_cutoff_reset_en_i && $rose(sync_r[PIN_RECOVER]) |-> drive_recovery_req_o)
		else $error("port 14 edge lost");
	a_cutoff_holds: assert property (
		cfg_cutoff_reset_en_i && cutoff_r && !rec_req |=> cutoff_r)
		else $error("cutoff dropped without request");
	a_cutoff_clears: assert property (
		cfg_cutoff_reset_en_i && cutoff_r && rec_req && !sync_r[PIN_CAUSE] |=> !cutoff_r)
		else $error("cutoff not cleared");
	a_port5_edge_req: assert property (
		cfg_pause_reset_en_i && $rose(sync_r[PIN_PRESET]) |-> pause_reset_req_o)
		else $error("port 5 edge lost");
	a_estop_pauses: assert property (
		s_estop_in_auto |=> op_pause_o)
		else $error("estop did not pause");
	a_dms_pauses: assert property (
		auto_mode_i && cfg_dms_rcv_i == RCV_CONTINUE && rise[PIN_DMS] |=> op_pause_o)
		else $error("switch stop did not pause");
	a_port6_holds_pause: assert property (
		(cfg_pause_sig_en_i && !sync_r[PIN_PAUSE]) [*2] |-> op_pause_o)
		else $error("port 6 low without pause");
	a_reset_clears_pause: assert property (
		pause_r && prs_req && !pause_cause |-> s_pause_cleared)
		else $error("pause reset ignored");
	a_cmd_equivalent: assert property (
		(drive_recovery_cmd_i |-> drive_recovery_req_o)
		and (pause_reset_cmd_i |-> pause_reset_req_o))
		else $error("command not taken");
	a_cmd_clears_cutoff: assert property (
		cfg_cutoff_reset_en_i && cutoff_r && drive_recovery_cmd_i && !sync_r[PIN_CAUSE]
		|=> !cutoff_r)
		else $error("recovery command ignored");
	a_host_to_ram: assert property (
		host_wr_i && st_r == S_IDLE |-> m.we && !flash_wr_req_o)
		else $error("host write not in ram");
	a_flash_reload: assert property (
		st_r == S_FLRD && flash_ack_i |-> m.we && m.wdata == flash_rdata_i)
		else $error("flash word not loaded");
	a_global_kept: assert property (
		mode_r == WM_BOOT && region == REG_GLOBAL && cfg_battery_i == BATT_SRAM |-> !m.we)
		else $error("global data overwritten");
	a_soft_reset_boot: assert property (
		soft_reset_i && st_r == S_IDLE && !flash_save_i
		|=> ##1 st_r == S_WALK && mode_r == WM_BOOT)
		else $error("soft reset did not restart");
	a_mfg_untouched: assert property (
		enc_wr_req_o |-> enc_addr_o >= ENC_USER_BASE)
		else $error("manufacturing word written");
	a_single_pulse: assert property (
		rise[PIN_RECOVER] |=> !rise[PIN_RECOVER])
		else $error("edge gave two pulses");
endmodule
`default_nettype wire

// ==== rtl/pdr_pkg.sv ====
// pdr_pkg: constants shared by the pause and drive-recovery interlock
// assumes one 25 MHz system clock and an active-low asynchronous reset
package pdr_pkg;
	// synchronised input pins
	localparam int unsigned PIN_N       = 6;
	localparam int unsigned PIN_RECOVER = 0;
	localparam int unsigned PIN_PRESET  = 1;
	localparam int unsigned PIN_PAUSE   = 2;
	localparam int unsigned PIN_ESTOP   = 3;
	localparam int unsigned PIN_DMS     = 4;
	localparam int unsigned PIN_CAUSE   = 5;
	localparam logic [PIN_N-1:0] PIN_IDLE = 6'h04; // idle pin levels, pause pin high
	// working memory geometry and region map (address bits 7:6)
	localparam int unsigned ADDR_W      = 8;
	localparam int unsigned DATA_W      = 16;
	localparam int unsigned DEPTH       = 256;
	localparam logic [1:0] REG_PROG     = 2'h0;
	localparam logic [1:0] REG_POS      = 2'h1;
	localparam logic [1:0] REG_GLOBAL   = 2'h2;
	localparam logic [1:0] REG_ENC      = 2'h3;
	localparam logic [ADDR_W-1:0] ADDR_FIRST    = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_LAST     = 8'hFF;
	localparam logic [ADDR_W-1:0] ENC_USER_BASE = 8'hC8;
	localparam logic [DATA_W-1:0] DATA_ZERO     = 16'h0000;
	// parameter settings
	localparam logic       FUNC_ON      = 1'b1;
	localparam logic [1:0] RCV_CONTINUE = 2'h2;
	localparam logic [1:0] BATT_NONE    = 2'h0;
	localparam logic [1:0] BATT_SRAM    = 2'h2;
	typedef enum logic [1:0] {WM_BOOT, WM_SAVE, WM_ENC} pdr_walk_t;
	typedef enum logic [2:0] {
		S_IDLE, S_WALK, S_FLRD, S_CLR, S_ENCRD, S_MRD, S_FLWR, S_ENCWR
	} pdr_state_t;
endpackage

// ==== rtl/pdr_mem_if.sv ====
// pdr_mem_if: port of the working memory
// assumes both ends sit on the same system clock
`timescale 1ns/10ps
`default_nettype none
interface pdr_mem_if;
	import pdr_pkg::*;
	logic              we;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	modport ctl (output we, output addr, output wdata, input rdata);
	modport mem (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ==== rtl/pdr_mem.sv ====
// pdr_mem: single-port working memory with registered read data
// assumes a synchronous write; contents are undefined until loaded
`timescale 1ns/10ps
`default_nettype none
module pdr_mem
	import pdr_pkg::*;
(
	// clock
	input wire logic  sys_clk_i,
	// access port
	pdr_mem_if.mem    m
);
	logic [DATA_W-1:0] ram [DEPTH];
	logic [DATA_W-1:0] rdata_r;

	// no reset on the array: restart contents come from the loader
	always_ff @(posedge sys_clk_i) begin
		if (m.we) begin
			ram[m.addr] <= m.wdata;
		end
		rdata_r <= ram[m.addr];
	end
	assign m.rdata = rdata_r;
endmodule
`default_nettype wire

// ==== tb/pdr_store_model.sv ====
// pdr_store_model: flash or encoder memory answering the interlock after a delay
// assumes a request is held until ack and carries one word per address
`timescale 1ns/10ps
`default_nettype none
module pdr_store_model
	import pdr_pkg::*;
#(
	parameter logic [7:0] TAG = 8'hA5,
	parameter int         LAT = 2
) (
	input  wire logic              clk_i,
	input  wire logic              rd_i,
	input  wire logic              wr_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [DATA_W-1:0] wdata_i,
	output logic      [DATA_W-1:0] rdata_o,
	output logic                   ack_o
);
	logic [DATA_W-1:0] mem [DEPTH];
	int                cnt;
	// preload a pattern naming the store and the address
	initial begin
		for (int i = 0; i < DEPTH; i++) begin
			mem[i] = {TAG, i[7:0]};
		end
		cnt = 0;
		ack_o = 1'b0;
		rdata_o = 16'h0000;
	end
	// data is only valid in the ack cycle; scrambled otherwise so stale reads show
	always @(posedge clk_i) begin
		ack_o <= 1'b0;
		rdata_o <= ~rdata_o;
		if ((rd_i || wr_i) && !ack_o) begin
			cnt <= cnt + 1;
			if (cnt == LAT) begin
				cnt <= 0;
				ack_o <= 1'b1;
				rdata_o <= mem[addr_i];
				if (wr_i) begin
					mem[addr_i] <= wdata_i;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== tb/test_pause_and_drive_recovery_interlock.sv ====
// test_pause_and_drive_recovery_interlock: self-checking bench of the interlock
// assumes the design's boot walk ends within 5000 cycles
`timescale 1ns/10ps
`default_nettype none
module test_pause_and_drive_recovery_interlock;
	import pdr_pkg::*;
	logic              sys_clk_i, arst_n_i, port14_recover_i, port5_preset_i, port6_pause_i;
	logic              estop_i, dms_stop_i, cutoff_cause_i, auto_mode_i;
	logic              cfg_cutoff_reset_en_i, cfg_pause_reset_en_i, cfg_pause_sig_en_i;
	logic [1:0]        cfg_estop_rcv_i, cfg_dms_rcv_i, cfg_battery_i;
	logic              drive_recovery_cmd_i, pause_reset_cmd_i, soft_reset_i, flash_save_i;
	logic              param_file_i, host_wr_i, busy_o, drive_cutoff_o, op_pause_o;
	logic              drive_recovery_req_o, pause_reset_req_o;
	logic [ADDR_W-1:0] host_addr_i, f_addr, e_addr;
	logic [DATA_W-1:0] host_wdata_i, host_rdata_o, f_wd, f_rd, e_wd, e_rd, d;
	logic              f_rq, f_wq, f_ack, e_rq, e_wq, e_ack;
	logic [1:0]        req_seen;
	int                fails, n_checks, n_drv, n_rst;
	pdr_interlock u_dut (.sys_clk_i, .arst_n_i, .port14_recover_i, .port5_preset_i,
		.port6_pause_i, .estop_i, .dms_stop_i, .cutoff_cause_i, .cfg_cutoff_reset_en_i,
		.cfg_pause_reset_en_i, .cfg_pause_sig_en_i, .cfg_estop_rcv_i, .cfg_dms_rcv_i,
		.cfg_battery_i, .auto_mode_i, .drive_recovery_cmd_i, .pause_reset_cmd_i,
		.soft_reset_i, .flash_save_i, .param_file_i, .host_wr_i, .host_addr_i,
		.host_wdata_i, .host_rdata_o, .busy_o, .drive_cutoff_o, .op_pause_o,
		.drive_recovery_req_o, .pause_reset_req_o, .flash_rd_req_o(f_rq),
		.flash_wr_req_o(f_wq), .flash_addr_o(f_addr), .flash_wdata_o(f_wd),
		.flash_rdata_i(f_rd), .flash_ack_i(f_ack), .enc_rd_req_o(e_rq), .enc_wr_req_o(e_wq),
		.enc_addr_o(e_addr), .enc_wdata_o(e_wd), .enc_rdata_i(e_rd), .enc_ack_i(e_ack));
	// prompt flash, slow encoder
	pdr_store_model #(.TAG(8'hA5), .LAT(1)) u_fl (.clk_i(sys_clk_i), .rd_i(f_rq),
		.wr_i(f_wq), .addr_i(f_addr), .wdata_i(f_wd), .rdata_o(f_rd), .ack_o(f_ack));
	pdr_store_model #(.TAG(8'h5E), .LAT(4)) u_enc (.clk_i(sys_clk_i), .rd_i(e_rq),
		.wr_i(e_wq), .addr_i(e_addr), .wdata_i(e_wd), .rdata_o(e_rd), .ack_o(e_ack));
	// request pulse counters
	always @(posedge sys_clk_i) begin
		if (drive_recovery_req_o === 1'b1) n_drv++;
		if (pause_reset_req_o === 1'b1) n_rst++;
	end
	initial begin
		sys_clk_i = 1'b0;
		forever #20 sys_clk_i = ~sys_clk_i;
	end
	task automatic summarize();
		if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic chk_b(input logic s, input logic e);
		check({15'h0000, s}, {15'h0000, e});
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask
	// bounded wait for the walk to finish
	task automatic wait_idle();
		tick(3);
		for (int k = 0; k < 5000; k++) begin
			if (busy_o === 1'b0) return;
			tick(1);
		end
		fails++;
		summarize();
	endtask
	// 0 recovery, 1 pause reset, 2 restart, 3 save, 4 parameter file
	task automatic pulse(input int w);
		@(posedge sys_clk_i);
		drive_recovery_cmd_i <= (w == 0);
		pause_reset_cmd_i <= (w == 1);
		soft_reset_i <= (w == 2);
		flash_save_i <= (w == 3);
		param_file_i <= (w == 4);
		#1 req_seen = {drive_recovery_req_o, pause_reset_req_o};
		@(posedge sys_clk_i);
		{drive_recovery_cmd_i, pause_reset_cmd_i, soft_reset_i} <= 3'h0;
		{flash_save_i, param_file_i} <= 2'h0;
		if (w > 1) wait_idle();
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge sys_clk_i);
		{host_wr_i, host_addr_i, host_wdata_i} <= {1'b1, a, v};
		@(posedge sys_clk_i);
		host_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk_i);
		host_addr_i <= a;
		tick(2);
		d = host_rdata_o;
	endtask
	task automatic t_restart();
		wait_idle();
		chk_b(op_pause_o | drive_cutoff_o, 1'b0);
		rd(8'h05); check(d, 16'hA5_05);
		rd(8'h45); check(d, 16'hA5_45);
		rd(8'h85); check(d, 16'h0000);
		rd(8'hC5); check(d, 16'h5EC5);
	endtask
	task automatic t_volatile();
		wr(8'h10, 16'h1234);
		wr(8'hC5, 16'h0000);
		rd(8'h10); check(d, 16'h1234);
		pulse(2);
		rd(8'h10); check(d, 16'hA510);
		rd(8'hC5); check(d, 16'h5EC5);
		wr(8'h10, 16'h1234);
		pulse(3);
		pulse(2);
		rd(8'h10); check(d, 16'h1234);
	endtask
	task automatic t_battery();
		cfg_battery_i <= BATT_SRAM;
		wr(8'h90, 16'hBEEF);
		pulse(2);
		rd(8'h90); check(d, 16'hBEEF);
		cfg_battery_i <= BATT_NONE;
		pulse(2);
		rd(8'h90); check(d, 16'h0000);
	endtask
	task automatic t_encwr();
		wr(8'hC8, 16'h0C0D);
		wr(8'hC0, 16'h1111);
		pulse(4);
		check(u_enc.mem[8'hC8], 16'h0C0D);
		check(u_enc.mem[8'hC0], 16'h5EC0);
	endtask
	task automatic t_cutoff();
		cutoff_cause_i <= 1'b1;
		port14_recover_i <= 1'b1;
		tick(6);
		chk_b(drive_cutoff_o, 1'b1);
		{cutoff_cause_i, port14_recover_i} <= 2'h0;
		tick(6);
		chk_b(drive_cutoff_o, 1'b1);
		n_drv = 0;
		port14_recover_i <= 1'b1;
		tick(8);
		check(n_drv[15:0], 16'h0001);
		chk_b(drive_cutoff_o, 1'b0);
		{cutoff_cause_i, port14_recover_i} <= 2'h2;
		tick(5);
		cutoff_cause_i <= 1'b0;
		tick(4);
		pulse(0);
		chk_b(req_seen[1], 1'b1);
		tick(1);
		chk_b(drive_cutoff_o, 1'b0);
		cfg_cutoff_reset_en_i <= 1'b0;
		cutoff_cause_i <= 1'b1;
		tick(5);
		cutoff_cause_i <= 1'b0;
		tick(5);
		chk_b(drive_cutoff_o, 1'b0);
		cfg_cutoff_reset_en_i <= 1'b1;
	endtask
	task automatic t_pause();
		port6_pause_i <= 1'b0;
		tick(5);
		chk_b(op_pause_o, 1'b1);
		port5_preset_i <= 1'b1;
		tick(6);
		chk_b(op_pause_o, 1'b1);
		{port5_preset_i, port6_pause_i} <= 2'h1;
		tick(6);
		chk_b(op_pause_o, 1'b1);
		n_rst = 0;
		port5_preset_i <= 1'b1;
		tick(8);
		check(n_rst[15:0], 16'h0001);
		chk_b(op_pause_o, 1'b0);
		port5_preset_i <= 1'b0;
	endtask
	// the two stop sources share one recovery path
	task automatic t_stops();
		auto_mode_i <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			{estop_i, dms_stop_i} <= k ? 2'h2 : 2'h1;
			tick(5);
			chk_b(op_pause_o, 1'b1);
			pulse(1);
			tick(2);
			chk_b(op_pause_o, 1'b1);
			{estop_i, dms_stop_i} <= 2'h0;
			tick(5);
			pulse(1);
			chk_b(req_seen[0], 1'b1);
			tick(2);
			chk_b(op_pause_o, 1'b0);
		end
		auto_mode_i <= 1'b0;
	endtask
	task automatic t_order();
		{cutoff_cause_i, port6_pause_i} <= 2'h2;
		tick(5);
		{cutoff_cause_i, port6_pause_i} <= 2'h1;
		tick(5);
		pulse(0);
		pulse(1);
		tick(2);
		chk_b(drive_cutoff_o | op_pause_o, 1'b0);
	endtask
	initial begin
		{fails, n_checks, n_drv, n_rst} = '0;
		{arst_n_i, port14_recover_i, port5_preset_i, estop_i, dms_stop_i} = 5'h00;
		{cutoff_cause_i, auto_mode_i, host_wr_i, drive_recovery_cmd_i} = 4'h0;
		{pause_reset_cmd_i, soft_reset_i, flash_save_i, param_file_i} = 4'h0;
		{port6_pause_i, cfg_cutoff_reset_en_i, cfg_pause_reset_en_i} = 3'h7;
		cfg_pause_sig_en_i = FUNC_ON;
		{cfg_estop_rcv_i, cfg_dms_rcv_i, cfg_battery_i} = {RCV_CONTINUE, RCV_CONTINUE, BATT_NONE};
		{host_addr_i, host_wdata_i} = '0;
		tick(10);
		arst_n_i <= 1'b1;
		t_restart();
		t_volatile();
		t_battery();
		t_encwr();
		t_cutoff();
		t_pause();
		t_stops();
		t_order();
		summarize();
	end
endmodule
`default_nettype wire
